// [core/bit_event_if.sv]
// bit clock events passed from the local clock divider to the distributor
`timescale 1ns/1ps
`default_nettype none
interface bit_event_if;
  logic advance;
  logic bit_edge;
  modport src (output advance, output bit_edge);
  modport dst (input advance, input bit_edge);
endinterface
`default_nettype wire

// [core/local_clock_divider.sv]
// gated local bit clock for start-stop operation
`timescale 1ns/1ps
`default_nettype none
module local_clock_divider
  import rxdist_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_BIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // run request and bit events
  input wire logic keep_run,
  bit_event_if.src ev
);
  div_state_t state_q;
  logic [DIV_W-1:0] cnt_q;
  logic level_q;
  wire running = (state_q == DIV_RUN);
  wire half_done = (cnt_q == DIV_W'(HALF_CYCLES - 1));

  // level starts high, so the first fall lands half a bit after start
  assign ev.advance = running & half_done & level_q;
  assign ev.bit_edge = running & half_done & ~level_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= DIV_IDLE;
      cnt_q <= '0;
      level_q <= 1'b1;
    end else begin
      case (state_q)
        DIV_IDLE: begin
          cnt_q <= '0;
          level_q <= 1'b1;
          if (keep_run) begin
            state_q <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          if (half_done) begin
            cnt_q <= '0;
            level_q <= ~level_q;
            // only stop at a bit boundary, never mid bit
            if (!level_q && !keep_run) begin
              state_q <= DIV_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + DIV_W'(1);
          end
        end
        default: begin
          state_q <= DIV_IDLE;
        end
      endcase
    end
  end

  a_clock_held:
  assert property (@(posedge clk) disable iff (!resetn)
    (running && keep_run) |=> running)
    else $error("local clock stopped while held running");
endmodule // local_clock_divider
`default_nettype wire

// [core/rxdist_pkg.sv]
// constants shared by the serial character receive distributor
package rxdist_pkg;
  localparam int STAGES = 10;
  localparam int DATA_BITS = 8;
  localparam int STOP_IDX = 9;
  localparam int START_IDX = 0;
  localparam logic MARK = 1'b1;
  localparam logic SPACE = 1'b0;
  // power-on contents of the shift stages and the sync loss flag
  localparam logic STOP_RESET = 1'b1;
  localparam logic START_RESET = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic SYNC_LOSS_RESET = 1'b1;
  // timing: system clock and the start-stop local bit rate
  localparam int CLK_HZ = 20000000;
  localparam int LOCAL_BAUD = 1050;
  localparam int HALF_BIT_CYCLES = CLK_HZ / (2 * LOCAL_BAUD);
  localparam int DIV_W = 16;
  localparam int HOLD_ADVANCES = 9;
  // local clock divider states
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN = 2'b10
  } div_state_t;
endpackage

// [core/serial_char_receive_distributor.sv]
// serial character receive distributor: ten stage framing shift register
//
// Contract
// - stop stage space sets restart latch; clear pulses
// - restart pulse marks all but stop stage
// - restart pulse clears sync loss flag
// - advance shifts stop and data stages one step down; start stage takes its gated input
// - synchronous runs always; start-stop halts after strobe
// - restart latch or start mark holds clock
// - start stage holds mark nine advances
// - strobes need start space, stop mark, flag clear
// - stop space at framing blocks readout strobe
// - eight data stages drive parallel outputs
// - readout strobe length depends on mode
// - late framing sets sync loss, blocking strobes
// - starts under half a bit ignored
// - idle synchronous keeps start stage spacing
// - short start stops local clock again
// - parity sample mirrors readout strobe precursor
// - advance on bit clock fall, mid bit
// - power-on loads stop mark, start space, flag
`timescale 1ns/1ps
`default_nettype none
module serial_char_receive_distributor
  import rxdist_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_BIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // line side, asynchronous to clk
  input wire logic line_data,
  input wire logic rx_clk,
  input wire logic sync_mode,
  // character outputs
  output var logic [DATA_BITS-1:0] data_out,
  output var logic char_strobe,
  output var logic readout_strobe,
  output var logic parity_sample
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [2:0] pins_s;
  logic rx_prev_q;

  sync2_cell #(.W(3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({sync_mode, rx_clk, line_data}),
    .q(pins_s)
  );

  wire line_s = pins_s[0];
  wire rx_s = pins_s[1];
  wire mode_sync = pins_s[2];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_s;
    end
  end

  // the data set clock falls at bit start; its rise is the inverted fall
  wire rx_rise = rx_s & ~rx_prev_q;
  wire rx_fall = ~rx_s & rx_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // bit clock selection

  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] stage_d;
  logic restart_q;
  logic restart_d;
  logic engaged_q;
  logic sync_loss_flag_q;
  logic sync_loss_flag_d;

  bit_event_if lc_ev ();

  // a short start bit never reaches the stop stage, so nothing here holds
  wire keep_run = ~mode_sync & (~line_s | restart_q | stage_q[START_IDX]);

  local_clock_divider #(.HALF_CYCLES(HALF_CYCLES)) u_local_clock_divider (
    .clk(clk),
    .resetn(resetn),
    .keep_run(keep_run),
    .ev(lc_ev.src)
  );

  // synchronous clock runs regardless of register contents
  wire advance = mode_sync ? rx_rise : lc_ev.advance;
  wire bit_edge = mode_sync ? rx_fall : lc_ev.bit_edge;

  ////////////////////////////////////////////////////////////////////////////
  // restart latch and pulse

  wire stop_side_stage = stage_q[STOP_IDX];
  wire start_side_stage = stage_q[START_IDX];
  // engaged while a start bit sits in the stop stage or a char assembles
  wire engaged = ~stop_side_stage | start_side_stage;
  wire restart_set = engaged & ~engaged_q;
  wire restart_pulse = restart_q & bit_edge;
  // set wins over the clear if both land together
  assign restart_d = restart_set | (restart_q & ~bit_edge);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      restart_q <= 1'b0;
      engaged_q <= 1'b0;
    end else begin
      restart_q <= restart_d;
      engaged_q <= engaged;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register

  // start stage input is gated by its own mark: once spacing it only
  // leaves space by a restart, which filters false starts
  wire start_gate = stage_q[START_IDX + 1] & start_side_stage;

  always_comb begin
    stage_d = stage_q;
    if (restart_pulse) begin
      stage_d[STOP_IDX-1:0] = {STOP_IDX{MARK}};
    end else if (advance) begin
      stage_d = {line_s, stage_q[STOP_IDX:START_IDX+2], start_gate};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage_q <= {STOP_RESET, DATA_RESET, START_RESET};
    end else begin
      stage_q <= stage_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync loss flag

  always_comb begin
    sync_loss_flag_d = sync_loss_flag_q;
    if (restart_pulse) begin
      sync_loss_flag_d = 1'b0;
    end else if (advance && !start_side_stage) begin
      sync_loss_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_loss_flag_q <= SYNC_LOSS_RESET;
    end else begin
      sync_loss_flag_q <= sync_loss_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes and character outputs

  // framed when start spaces and stop marks; stop space blocks readout
  wire framed = ~start_side_stage & stop_side_stage;
  wire strobe_pre = framed & ~sync_loss_flag_q;

  // no punch blinds here, so both strobes share one precursor
  assign char_strobe = strobe_pre;
  assign readout_strobe = strobe_pre;
  assign parity_sample = strobe_pre;
  assign data_out = stage_q[STOP_IDX-1:START_IDX+1];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // advances since the last restart; saturates so a long idle never wraps
  logic [3:0] adv_cnt_q;
  logic armed_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      adv_cnt_q <= 4'h0;
      armed_q <= 1'b0;
    end else if (restart_pulse) begin
      adv_cnt_q <= 4'h0;
      armed_q <= 1'b1;
    end else if (advance && adv_cnt_q != 4'hf) begin
      adv_cnt_q <= adv_cnt_q + 4'h1;
    end
  end

  a_restart_once:
  assert property (@(posedge clk) disable iff (!resetn)
    restart_pulse |=> (!restart_q && !restart_pulse))
    else $error("restart latch not cleared after pulse");

  a_restart_marks:
  assert property (@(posedge clk) disable iff (!resetn)
    restart_pulse |=> (stage_q[8:0] == 9'h1ff && stage_q[9] == $past(stage_q[9])))
    else $error("restart pulse did not mark stages");

  a_restart_flag:
  assert property (@(posedge clk) disable iff (!resetn)
    restart_pulse |=> !sync_loss_flag_q)
    else $error("restart pulse did not clear sync loss flag");

  a_shift_step:
  assert property (@(posedge clk) disable iff (!resetn)
    (advance && !restart_pulse) |=>
      (stage_q[8:1] == $past(stage_q[9:2]) && stage_q[9] == $past(line_s)))
    else $error("shift register did not step");

  a_start_hold:
  assert property (@(posedge clk) disable iff (!resetn)
    (armed_q && advance && !restart_pulse && adv_cnt_q < 4'(HOLD_ADVANCES - 1)) |=>
      start_side_stage)
    else $error("start stage lost mark before ninth advance");

  a_start_ninth:
  assert property (@(posedge clk) disable iff (!resetn)
    (armed_q && advance && !restart_pulse && adv_cnt_q == 4'(HOLD_ADVANCES - 1)) |=>
      !start_side_stage)
    else $error("start bit not in start stage at ninth advance");

  a_flag_blocks:
  assert property (@(posedge clk) disable iff (!resetn)
    (advance && !restart_pulse && !start_side_stage) |=>
      (sync_loss_flag_q && !readout_strobe && !char_strobe))
    else $error("sync loss not set or strobes not blocked");

  a_sync_one_bit:
  assert property (@(posedge clk) disable iff (!resetn)
    (mode_sync && readout_strobe && advance) |=> !readout_strobe)
    else $error("synchronous readout strobe exceeded one bit");

  a_idle_space:
  assert property (@(posedge clk) disable iff (!resetn)
    (!start_side_stage && !restart_pulse) |=> !start_side_stage)
    else $error("mark entered start stage without restart");

  // reset is synchronous, so the power-on state shows one edge later
  a_power_state:
  assert property (@(posedge clk) !resetn |=>
    (stop_side_stage == STOP_RESET && start_side_stage == START_RESET &&
      sync_loss_flag_q == SYNC_LOSS_RESET && !readout_strobe))
    else $error("power-on state not loaded");

  // only a start bit arriving from idle arms the latch
  a_restart_sets:
  assert property (@(posedge clk) disable iff (!resetn)
    ($fell(stop_side_stage) && !$past(start_side_stage)) |=> restart_q)
    else $error("restart latch not set by start bit");

  a_restart_cause:
  assert property (@(posedge clk) disable iff (!resetn)
    $rose(restart_q) |-> !stop_side_stage)
    else $error("restart latch set without start bit in stop stage");

  // the flag only sets on an advance, never between them
  a_flag_holds:
  assert property (@(posedge clk) disable iff (!resetn)
    (!sync_loss_flag_q && !advance) |=> !sync_loss_flag_q)
    else $error("sync loss flag set outside framing check");

  // once set, only a restart pulse lifts the flag
  a_flag_sticky:
  assert property (@(posedge clk) disable iff (!resetn)
    (sync_loss_flag_q && !restart_pulse) |=> (sync_loss_flag_q && !readout_strobe))
    else $error("sync loss flag dropped without restart");

  a_stage_holds:
  assert property (@(posedge clk) disable iff (!resetn)
    (!advance && !restart_pulse) |=> $stable(stage_q))
    else $error("shift register moved without advance");

  // the reader may take the levels at any cycle of the strobe
  a_data_steady:
  assert property (@(posedge clk) disable iff (!resetn)
    (readout_strobe && $past(readout_strobe)) |-> $stable(data_out))
    else $error("data outputs changed while readout strobe high");

  // a strobe can only start from the advance that completes a frame
  a_strobe_rise:
  assert property (@(posedge clk) disable iff (!resetn)
    $rose(char_strobe) |-> $past(advance))
    else $error("character strobe rose without an advance");

  // start-stop keeps the character until the clock runs again
  a_strobe_holds:
  assert property (@(posedge clk) disable iff (!resetn)
    (!mode_sync && readout_strobe && !advance) |=> readout_strobe)
    else $error("start-stop readout strobe dropped early");

endmodule // serial_char_receive_distributor
`default_nettype wire

// [core/sync2_cell.sv]
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2_cell #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= '1;
      q <= '1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sync2_cell
`default_nettype wire

// [tb/data_set_model.sv]
// line side data set model: serial frames and receive clock
`timescale 1ns/1ps
`default_nettype none
module data_set_model (
  // serial line and receive clock
  output var logic line_data,
  output var logic rx_clk
);
  logic clk_run;
  initial begin
    line_data = 1'b1;
    rx_clk = 1'b1;
    clk_run = 1'b0;
  end
  // free running in sync mode, parked high otherwise
  always #200 rx_clk = clk_run ? ~rx_clk : 1'b1;
  //////////////////////////////
  // one frame, first data bit first; stop_ok low sends a spacing stop
  task automatic send(input logic [7:0] b, input logic stop_ok);
    logic [9:0] f;
    f = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (clk_run) @(negedge rx_clk);
      line_data = f[i];
      if (!clk_run) #800;
    end
    if (clk_run) @(negedge rx_clk);
    line_data = 1'b1;
  endtask
  // receive clock runs free from here on, for synchronous operation
  task automatic start_clock();
    clk_run = 1'b1;
  endtask
  // spacing glitch shorter than half a bit
  task automatic glitch();
    line_data = 1'b0;
    #300 line_data = 1'b1;
  endtask
endmodule // data_set_model
`default_nettype wire

// [tb/serial_char_receive_distributor_test.sv]
// self-checking bench for the serial character receive distributor
`timescale 1ns/1ps
`default_nettype none
module serial_char_receive_distributor_test
  import rxdist_pkg::*;
;
  logic clk, resetn, sync_mode, line_data, rx_clk, lo, hi;
  logic [DATA_BITS-1:0] data_out;
  logic char_strobe, readout_strobe, parity_sample;
  int errors, checks, cycles;
  // short half bit keeps start-stop frames at 16 clocks a bit
  serial_char_receive_distributor #(.HALF_CYCLES(8)) dut (
    .clk(clk), .resetn(resetn), .line_data(line_data), .rx_clk(rx_clk),
    .sync_mode(sync_mode), .data_out(data_out), .char_strobe(char_strobe),
    .readout_strobe(readout_strobe), .parity_sample(parity_sample));
  data_set_model ds (.line_data(line_data), .rx_clk(rx_clk));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      results();
    end
  end
  //////////////////////////////
  task automatic results();
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_lvl(input logic lvl, input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      if (seen == 1'b0) begin
        @(posedge clk);
        #1 seen = (readout_strobe === lvl);
      end
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    resetn = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // strobe must drop for the new start bit, then rise only on a good frame
  task automatic t_frame(input logic [7:0] b, input logic stop_ok, input int n);
    logic l, h;
    fork
      ds.send(b, stop_ok);
      begin
        wait_lvl(1'b0, 400, l);
        chk("strobe_drop", 8'h01, {7'h00, l});
        wait_lvl(1'b1, n, h);
        chk("strobe", {7'h00, stop_ok}, {7'h00, h});
        if (h === 1'b1) begin
          chk("data_out", b, data_out);
          chk("char_strobe", 8'h01, {7'h00, char_strobe});
          chk("parity_sample", 8'h01, {7'h00, parity_sample});
        end
      end
    join
  endtask
  // start-stop: strobe and data stay put once the clock halts
  task automatic t_hold(input logic [7:0] b);
    repeat (64) @(posedge clk);
    #1;
    chk("held_strobe", 8'h01, {7'h00, readout_strobe});
    chk("held_data", b, data_out);
  endtask
  //////////////////////////////
  initial begin
    resetn = 1'b0;
    sync_mode = 1'b0;
    do_reset();
    chk("reset_data", 8'hff, data_out);
    chk("reset_strobe", 8'h00, {7'h00, readout_strobe});
    ds.glitch();
    wait_lvl(1'b1, 300, hi);
    chk("glitch_strobe", 8'h00, {7'h00, hi});
    t_frame(8'ha5, 1'b1, 170);
    t_hold(8'ha5);
    t_frame(8'h3c, 1'b1, 170);
    t_hold(8'h3c);
    t_frame(8'h0f, 1'b0, 170);
    @(negedge clk);
    sync_mode = 1'b1;
    ds.start_clock();
    do_reset();
    wait_lvl(1'b1, 200, hi);
    chk("idle_sync", 8'h00, {7'h00, hi});
    t_frame(8'h5a, 1'b1, 120);
    wait_lvl(1'b0, 16, lo);
    chk("sync_strobe_end", 8'h01, {7'h00, lo});
    wait_lvl(1'b1, 100, hi);
    chk("sync_blocked", 8'h00, {7'h00, hi});
    results();
  end
endmodule // serial_char_receive_distributor_test
`default_nettype wire
